// *** spi_cfg_pkg.sv ***
// Purpose: Constants and types of the serial config block
// Assumes: Register index times four gives the APB byte address
// Notes:   Only each word's low byte is used
package spi_cfg_pkg;
    localparam int         ADDR_W              = 6;
    localparam logic [3:0] IDX_CTRL1           = 4'h0;
    localparam logic [3:0] IDX_CTRL2           = 4'h1;
    localparam logic [3:0] IDX_BAUD            = 4'h2;
    localparam logic [3:0] IDX_STATUS          = 4'h3;
    localparam logic [3:0] IDX_DATA            = 4'h5;
    localparam logic [3:0] IDX_IRQ_STATUS      = 4'h8;
    localparam logic [3:0] IDX_IRQ_MASK        = 4'h9;

    localparam int         CR1_RX_FAULT_IRQ_EN = 7;
    localparam int         CR1_SYS_EN          = 6;
    localparam int         CR1_TX_EMPTY_IRQ_EN = 5;
    localparam int         CR1_ROLE            = 4;
    localparam int         CR1_CLOCK_POLARITY_BIT            = 3;
    localparam int         CR1_CLOCK_PHASE_BIT            = 2;
    localparam int         CR1_SEL_OE          = 1;
    localparam int         CR1_LSB_FIRST       = 0;
    localparam int         CR2_FAULT_EN        = 4;
    localparam int         SR_DONE             = 7;
    localparam int         SR_TX_EMPTY         = 5;
    localparam int         SR_FAULT            = 4;
    localparam int         EV_DONE             = 0;
    localparam int         EV_TX_EMPTY         = 1;
    localparam int         EV_FAULT            = 2;

    localparam logic [7:0] CTRL1_RESET         = 8'h04;
    localparam logic [7:0] CTRL2_RESET         = 8'h00;
    localparam logic [7:0] CTRL2_WRITE_MASK    = 8'h10;
    localparam logic [7:0] BAUD_RESET          = 8'h03;
    localparam logic [2:0] IRQ_MASK_RESET      = 3'h0;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_RUN    = 3'b010,
        ST_FINISH = 3'b100
    } xfer_state_t;

    function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] addr);
        reg_index = addr[5:2];
    endfunction : reg_index
endpackage : spi_cfg_pkg

// *** pin_sync.sv ***
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes:   Only stage two reads stage one
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    if (WIDTH < 1) begin : g_check
        $error("pin_sync needs at least one bit");
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : pin_sync

// *** shift_engine.sv ***
// Purpose: Serial shifter with selectable bit order
// Assumes: Sample strobe precedes its shift strobe
// Notes:   Bit positions are the same in either order
`timescale 1ns/100ps
module shift_engine #(
    parameter int WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_data,
    input  wire logic             sample,
    input  wire logic             shift,
    input  wire logic             lsb_first,
    input  wire logic             serial_in,
    output logic                  serial_out,
    output logic      [WIDTH-1:0] data
);
    logic [WIDTH-1:0] shifter;
    logic [WIDTH-1:0] next_shifter;
    logic             rx_bit;
    logic             next_rx_bit;

    if (WIDTH < 2) begin : g_check
        $error("shift_engine needs at least two bits");
    end

    always_comb begin
        next_rx_bit  = sample ? serial_in : rx_bit;
        next_shifter = shifter;
        if (load) begin
            next_shifter = load_data;
        end else if (shift) begin
            // Order changes direction, not positions
            if (lsb_first) begin
                next_shifter = {rx_bit, shifter[WIDTH-1:1]};
            end else begin
                next_shifter = {shifter[WIDTH-2:0], rx_bit};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shifter <= '0;
            rx_bit  <= 1'b0;
        end else begin
            shifter <= next_shifter;
            rx_bit  <= next_rx_bit;
        end
    end

    assign serial_out = lsb_first ? shifter[0] : shifter[WIDTH-1];
    assign data       = shifter;
endmodule : shift_engine

// *** spi_control_and_select_config.sv ***
// Purpose: Serial port control, role, clock format and select pin
// Assumes: APB slave; link pins asynchronous
// Notes:   Link clock must be well below pclk
// Function
// - Done or fault flag interrupts only while rx/fault enable is set
// - System enable low holds idle and clears done, fault and transmit-full flags
// - System enable high gives the pins to the port, select only as controller with fault enable and select output
// - Transmit-empty flag interrupts only while its enable is set
// - Role bit picks target or controller; changing it forces idle
// - Polarity bit sets serial clock idle level low or high
// - Phase bit samples odd edges when low, even when high
// - Controller aborts transfer when polarity, phase, select or order changes
// - Order bit shifts most significant first when low, least when high
// - Data register keeps most significant bit on top in both orders
// - Controller with fault enable and select output drives select pin
// - Controller with fault enable only watches select pin for faults
// - Select driven only as controller; target always uses it as input
// - Fault enable in second control register allows fault detection
`timescale 1ns/100ps
module spi_control_and_select_config
    import spi_cfg_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq,
    input  wire logic              sck_in,
    output logic                   sck_out,
    output logic                   sck_oe,
    input  wire logic              mosi_in,
    output logic                   mosi_out,
    output logic                   mosi_oe,
    input  wire logic              miso_in,
    output logic                   miso_out,
    output logic                   miso_oe,
    input  wire logic              ss_in,
    output logic                   ss_out,
    output logic                   ss_oe
);
    if (WIDTH != 8) begin : g_check
        $error("data register is one byte wide");
    end

    logic [7:0]  ctrl1, next_ctrl1;
    logic [7:0]  ctrl2, next_ctrl2;
    logic [7:0]  baud, next_baud;
    logic [7:0]  tx_data, next_tx_data;
    logic [7:0]  rx_data, next_rx_data;
    logic        tx_full, next_tx_full;
    logic        done_flag, next_done_flag;
    logic        fault_flag, next_fault_flag;
    logic [2:0]  irq_status, next_irq_status;
    logic [2:0]  irq_mask, next_irq_mask;
    xfer_state_t state, next_state;
    logic [4:0]  edge_cnt, next_edge_cnt;
    logic [7:0]  div_cnt, next_div_cnt;
    logic        sck_level, next_sck_level;
    logic        pending, next_pending;
    logic        sck_prev;
    logic [31:0] next_prdata;
    logic        next_pready, next_pslverr, next_irq;
    logic        next_sck_out, next_sck_oe, next_mosi_out, next_mosi_oe;
    logic        next_miso_out, next_miso_oe, next_ss_out, next_ss_oe;
    logic [3:0]  pins_s;
    logic        sck_s, mosi_s, miso_s, ss_s;
    logic        wr, rd, mapped;
    logic [3:0]  idx;
    logic        sys_en, role, clock_polarity_bit, clock_phase_bit, sel_oe, lsb_first, fault_en;
    logic        role_change, cfg_change, fault_detect, abort;
    logic        link_edge, sample_now, shift_now, load, capture;
    logic [2:0]  events, gate;
    logic        serial_out;
    logic [7:0]  shift_data;

    pin_sync #(
        .WIDTH (4)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({sck_in, mosi_in, miso_in, ss_in}),
        .sync_out (pins_s)
    );
    assign {sck_s, mosi_s, miso_s, ss_s} = pins_s;

    shift_engine #(
        .WIDTH (WIDTH)
    ) u_engine (
        .pclk       (pclk),
        .presetn    (presetn),
        .load       (load),
        .load_data  (tx_data),
        .sample     (sample_now),
        .shift      (shift_now),
        .lsb_first  (lsb_first),
        .serial_in  (role ? miso_s : mosi_s),
        .serial_out (serial_out),
        .data       (shift_data)
    );

    assign sys_en    = ctrl1[CR1_SYS_EN];
    assign role      = ctrl1[CR1_ROLE];
    assign clock_polarity_bit      = ctrl1[CR1_CLOCK_POLARITY_BIT];
    assign clock_phase_bit      = ctrl1[CR1_CLOCK_PHASE_BIT];
    assign sel_oe    = ctrl1[CR1_SEL_OE];
    assign lsb_first = ctrl1[CR1_LSB_FIRST];
    assign fault_en  = ctrl2[CR2_FAULT_EN];
    assign gate      = {ctrl1[CR1_RX_FAULT_IRQ_EN], ctrl1[CR1_TX_EMPTY_IRQ_EN],
                        ctrl1[CR1_RX_FAULT_IRQ_EN]};

    // pready set in setup, so no wait state
    always_comb begin
        idx    = reg_index(paddr);
        mapped = (paddr[1:0] == 2'h0) &&
                 (idx == IDX_CTRL1 || idx == IDX_CTRL2 || idx == IDX_BAUD ||
                  idx == IDX_STATUS || idx == IDX_DATA ||
                  idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK);
        wr     = psel && penable && pready && pwrite && mapped;
        rd     = psel && penable && pready && !pwrite && mapped;
    end

    always_comb begin
        role_change  = wr && idx == IDX_CTRL1 && (pwdata[CR1_ROLE] != role);
        cfg_change   = wr && ((idx == IDX_CTRL1 && pwdata[3:0] != ctrl1[3:0]) ||
                       (idx == IDX_CTRL2 && pwdata[CR2_FAULT_EN] != fault_en));
        // Select low while watched: another controller drives
        fault_detect = sys_en && role && fault_en && !sel_oe && !ss_s;
        abort        = !sys_en || role_change || (role && cfg_change) || fault_detect;
    end

    // Link edges and sampling
    always_comb begin
        if (role) begin
            link_edge = (state == ST_RUN) && (div_cnt == 8'h00);
        end else begin
            link_edge = (state == ST_RUN) && (sck_s != sck_prev) && !ss_s;
        end
        sample_now = link_edge && (edge_cnt[0] == clock_phase_bit);
        shift_now  = pending && ((link_edge && !sample_now) || state == ST_FINISH);
    end

    always_comb begin
        next_state     = state;
        next_edge_cnt  = edge_cnt;
        next_div_cnt   = div_cnt;
        next_sck_level = sck_level;
        next_pending   = pending;
        load           = 1'b0;
        capture        = 1'b0;
        if (sample_now) begin
            next_pending = 1'b1;
        end else if (shift_now) begin
            next_pending = 1'b0;
        end
        unique case (state)
            ST_IDLE: begin
                next_sck_level = clock_polarity_bit;
                next_edge_cnt  = 5'h00;
                next_pending   = 1'b0;
                if (sys_en && role && tx_full && !fault_detect) begin
                    next_state   = ST_RUN;
                    next_div_cnt = baud;
                    load         = 1'b1;
                end else if (sys_en && !role && !ss_s) begin
                    next_state = ST_RUN;
                    load       = tx_full;
                end
            end
            ST_RUN: begin
                if (role) begin
                    next_div_cnt = (div_cnt == 8'h00) ? baud : div_cnt - 8'h01;
                end
                if (link_edge) begin
                    next_sck_level = !sck_level;
                    next_edge_cnt  = edge_cnt + 5'h01;
                    if (edge_cnt == 5'(2 * WIDTH - 1)) begin
                        next_state = ST_FINISH;
                    end
                end
                if (!role && ss_s) begin
                    next_state = ST_IDLE;
                end
            end
            ST_FINISH: begin
                // Phase one shifts last here
                if (!pending) begin
                    capture    = 1'b1;
                    next_state = ST_IDLE;
                end
            end
        endcase
        if (abort) begin
            next_state   = ST_IDLE;
            next_pending = 1'b0;
            load         = 1'b0;
            capture      = 1'b0;
        end
    end

    // Hardware set wins over software clear
    always_comb begin
        next_ctrl1      = ctrl1;
        next_ctrl2      = ctrl2;
        next_baud       = baud;
        next_tx_data    = tx_data;
        next_irq_mask   = irq_mask;
        next_tx_full    = tx_full;
        next_done_flag  = done_flag;
        next_fault_flag = fault_flag;
        next_rx_data    = capture ? shift_data : rx_data;
        if (wr) begin
            unique case (idx)
                IDX_CTRL1:    next_ctrl1    = pwdata[7:0];
                IDX_CTRL2:    next_ctrl2    = pwdata[7:0] & CTRL2_WRITE_MASK;
                IDX_BAUD:     next_baud     = pwdata[7:0];
                IDX_DATA:     next_tx_data  = pwdata[7:0];
                IDX_IRQ_MASK: next_irq_mask = pwdata[2:0];
                default:      next_ctrl1    = ctrl1;
            endcase
        end
        if (wr && idx == IDX_DATA) begin
            next_tx_full = 1'b1;
        end else if (load) begin
            next_tx_full = 1'b0;
        end
        if (rd && idx == IDX_DATA) begin
            next_done_flag = 1'b0;
        end
        if (capture) begin
            next_done_flag = 1'b1;
        end
        if (wr && idx == IDX_CTRL1) begin
            next_fault_flag = 1'b0;
        end
        if (fault_detect) begin
            next_fault_flag = 1'b1;
        end
        if (!sys_en) begin
            next_tx_full    = 1'b0;
            next_done_flag  = 1'b0;
            next_fault_flag = 1'b0;
        end
        events = '0;
        events[EV_DONE]     = capture;
        events[EV_TX_EMPTY] = tx_full && !next_tx_full;
        events[EV_FAULT]    = fault_detect && !fault_flag;
        next_irq_status = irq_status;
        if (wr && idx == IDX_IRQ_STATUS) begin
            next_irq_status = irq_status & ~pwdata[2:0];
        end
        next_irq_status = next_irq_status | events;
        // Level output while any enabled bit holds
        next_irq = |(irq_status & irq_mask & gate);
    end

    // Bus answer and pin drivers
    always_comb begin
        next_pready  = psel && !penable;
        next_pslverr = psel && !penable && !mapped;
        next_prdata  = prdata;
        if (psel && !penable) begin
            next_prdata = 32'h0000_0000;
            unique case (reg_index(paddr))
                IDX_CTRL1:      next_prdata[7:0] = ctrl1;
                IDX_CTRL2:      next_prdata[7:0] = ctrl2;
                IDX_BAUD:       next_prdata[7:0] = baud;
                IDX_STATUS: begin
                    next_prdata[SR_DONE]     = done_flag;
                    next_prdata[SR_TX_EMPTY] = !tx_full;
                    next_prdata[SR_FAULT]    = fault_flag;
                end
                IDX_DATA:       next_prdata[7:0] = rx_data;
                IDX_IRQ_STATUS: next_prdata[2:0] = irq_status;
                IDX_IRQ_MASK:   next_prdata[2:0] = irq_mask;
                default:        next_prdata      = 32'h0000_0000;
            endcase
        end
        next_sck_oe   = sys_en && role;
        next_sck_out  = role ? sck_level : clock_polarity_bit;
        next_mosi_oe  = sys_en && role;
        next_mosi_out = serial_out;
        // Driven only while selected, so targets share it
        next_miso_oe  = sys_en && !role && !ss_s;
        next_miso_out = serial_out;
        next_ss_oe    = sys_en && role && fault_en && sel_oe;
        next_ss_out   = (state == ST_IDLE);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1      <= CTRL1_RESET;
            ctrl2      <= CTRL2_RESET;
            baud       <= BAUD_RESET;
            tx_data    <= 8'h00;
            rx_data    <= 8'h00;
            tx_full    <= 1'b0;
            done_flag  <= 1'b0;
            fault_flag <= 1'b0;
            irq_status <= 3'h0;
            irq_mask   <= IRQ_MASK_RESET;
            state      <= ST_IDLE;
            edge_cnt   <= 5'h00;
            div_cnt    <= 8'h00;
            sck_level  <= 1'b0;
            pending    <= 1'b0;
            sck_prev   <= 1'b0;
            prdata     <= 32'h0000_0000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            irq        <= 1'b0;
            sck_out    <= 1'b0;
            sck_oe     <= 1'b0;
            mosi_out   <= 1'b0;
            mosi_oe    <= 1'b0;
            miso_out   <= 1'b0;
            miso_oe    <= 1'b0;
            ss_out     <= 1'b1;
            ss_oe      <= 1'b0;
        end else begin
            ctrl1      <= next_ctrl1;
            ctrl2      <= next_ctrl2;
            baud       <= next_baud;
            tx_data    <= next_tx_data;
            rx_data    <= next_rx_data;
            tx_full    <= next_tx_full;
            done_flag  <= next_done_flag;
            fault_flag <= next_fault_flag;
            irq_status <= next_irq_status;
            irq_mask   <= next_irq_mask;
            state      <= next_state;
            edge_cnt   <= next_edge_cnt;
            div_cnt    <= next_div_cnt;
            sck_level  <= next_sck_level;
            pending    <= next_pending;
            sck_prev   <= sck_s;
            prdata     <= next_prdata;
            pready     <= next_pready;
            pslverr    <= next_pslverr;
            irq        <= next_irq;
            sck_out    <= next_sck_out;
            sck_oe     <= next_sck_oe;
            mosi_out   <= next_mosi_out;
            mosi_oe    <= next_mosi_oe;
            miso_out   <= next_miso_out;
            miso_oe    <= next_miso_oe;
            ss_out     <= next_ss_out;
            ss_oe      <= next_ss_oe;
        end
    end
endmodule : spi_control_and_select_config

// *** spi_cfg_sva.sv ***
// Purpose: Port checks of the serial block
// Assumes: Sees only top-level ports
// Notes:   Control and mask shadows follow bus writes
`timescale 1ns/100ps
module spi_cfg_sva
    import spi_cfg_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [5:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic        sck_out,
    input wire logic        sck_oe,
    input wire logic        mosi_oe,
    input wire logic        miso_oe,
    input wire logic        ss_out,
    input wire logic        ss_oe
);
    logic [7:0] c1, c2, mk, next_c1, next_c2, next_mk;
    logic       wr, ss_ok;
    assign wr    = psel && penable && pready && pwrite;
    assign ss_ok = c1[4] && c1[1] && c2[4];
    always_comb begin
        next_c1 = (wr && paddr == 6'h00) ? pwdata[7:0] : c1;
        next_c2 = (wr && paddr == 6'h04) ? (pwdata[7:0] & CTRL2_WRITE_MASK) : c2;
        next_mk = (wr && paddr == 6'h24) ? {5'h00, pwdata[2:0]} : mk;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c1 <= CTRL1_RESET;
            c2 <= 8'h00;
            mk <= 8'h00;
        end else begin
            c1 <= next_c1;
            c2 <= next_c2;
            mk <= next_mk;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    pready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no pready");
    pready_single_a: assert property (pready |=> !pready)
        else $error("pready too long");
    unmapped_error_a: assert property (psel && penable && pready && paddr == 6'h18
        |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    ctrl_readback_a: assert property (psel && penable && pready && !pwrite && paddr == 6'h00
        |-> prdata == {24'h0, c1}) else $error("bad readback");
    irq_gate_a: assert property (irq |-> $past(|(mk[2:0] & {c1[7], c1[5], c1[7]})))
        else $error("irq not enabled");
    ss_drive_a: assert property (ss_oe |-> ss_ok || $past(ss_ok) || $past(ss_ok, 2))
        else $error("select driven wrongly");
    disabled_pins_a: assert property (!c1[6] && !$past(c1[6]) && !$past(c1[6], 2)
        |-> !(sck_oe || mosi_oe || miso_oe || ss_oe)) else $error("pins driven when off");
    ctrl_pins_a: assert property (c1[6] && c1[4] && (c1[1] || !c2[4]) && $stable(c1)
        && c1 == $past(c1, 2) |-> sck_oe && mosi_oe && !miso_oe) else $error("controller pins");
    sck_idle_a: assert property (sck_oe && ss_oe && ss_out && $stable(c1) && c1 == $past(c1, 2)
        && c1 == $past(c1, 3) |-> sck_out == c1[3]) else $error("clock idle wrong");
    abort_idle_a: assert property (wr && paddr == 6'h00 && c1[4] && pwdata[3:0] != c1[3:0]
        |-> ##[1:4] (ss_out || !ss_oe)) else $error("no abort");
endmodule : spi_cfg_sva

bind spi_control_and_select_config spi_cfg_sva u_spi_cfg_sva (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .sck_out,
    .sck_oe, .mosi_oe, .miso_oe, .ss_out, .ss_oe);

// *** spi_link_peer.sv ***
// Purpose: Target device at the link's far end
// Assumes: Select active low; block makes the clock
// Notes:   Always shifts MSB first
`timescale 1ns/100ps
module spi_link_peer #(
    parameter logic [7:0] TX_BYTE = 8'hc1
) (
    input  wire logic       sck,
    input  wire logic       ss_n,
    input  wire logic       mosi,
    input  wire logic       clock_polarity_bit,
    input  wire logic       clock_phase_bit,
    output logic            miso,
    output logic [7:0]      rx,
    output logic            pol_ok
);
    int         n;
    logic [7:0] sh;
    initial begin
        miso   = 1'b1;
        rx     = 8'h00;
        pol_ok = 1'b1;
    end
    always @(negedge ss_n) begin
        n      = 0;
        sh     = TX_BYTE;
        pol_ok = (sck === clock_polarity_bit);
        if (!clock_phase_bit) begin
            miso = sh[7];
            sh   = sh << 1;
        end
    end
    always @(sck) begin
        if (ss_n === 1'b0) begin
            n++;
            if (n[0] != clock_phase_bit) rx = {rx[6:0], mosi};
            else begin
                miso = sh[7];
                sh   = sh << 1;
            end
        end
    end
    // Released line shows no stale bit
    always @(posedge ss_n) miso = ~miso;
endmodule : spi_link_peer

// *** spi_control_and_select_config_tb_top.sv ***
// Purpose: Self-checking bench of the serial block
// Assumes: Block is controller facing the model target
// Notes:   Baud reset gives an 800 ns link clock
`timescale 1ns/100ps
module spi_control_and_select_config_tb_top
    import spi_cfg_pkg::*;
;
    localparam logic [7:0] PEER_BYTE = 8'hc1;
    typedef struct packed {
        logic [7:0] c1;
        logic [7:0] c2;
        logic [3:0] oe;
        logic       sck;
    } row_t;
    // Enables: sck, mosi, miso, ss
    row_t rows [5] = '{'{8'h52, 8'h10, 4'hd, 1'b0}, '{8'h5a, 8'h00, 4'hc, 1'b1},
        '{8'h50, 8'h10, 4'hc, 1'b0}, '{8'h42, 8'h10, 4'h0, 1'b0}, '{8'h12, 8'h10, 4'h0, 1'b0}};
    logic [7:0]  modes [4] = '{8'hd2, 8'hdf, 8'h56, 8'h5b};
    logic        pclk, presetn, psel, penable, pwrite, ss_lvl, err, pready, pslverr, irq;
    logic        sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_out, ss_oe;
    logic        peer_miso, pol_ok, peer_ss_n;
    logic [5:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  peer_rx, c1, d;
    int          num_errors = 0, check_count = 0, cyc = 0, k, n;
    assign peer_ss_n = ss_oe ? ss_out : 1'b1;
    spi_control_and_select_config u_spi_control_and_select_config (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
        .sck_in(sck_oe ? sck_out : 1'b0), .sck_out, .sck_oe, .mosi_in(mosi_oe ? mosi_out : 1'b0),
        .mosi_out, .mosi_oe, .miso_in(peer_miso), .miso_out, .miso_oe,
        .ss_in(ss_oe ? ss_out : ss_lvl), .ss_out, .ss_oe);
    spi_link_peer #(.TX_BYTE(PEER_BYTE)) u_spi_link_peer (.sck(sck_out), .ss_n(peer_ss_n),
        .mosi(mosi_out), .clock_polarity_bit(c1[3]), .clock_phase_bit(c1[2]), .miso(peer_miso), .rx(peer_rx),
        .pol_ok(pol_ok));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
            num_errors++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [5:0] a, input logic [7:0] v);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, v};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [5:0] a, input logic [7:0] exp, input string nm);
        apb(1'b0, a, 8'h00);
        chk(nm, {24'h0, exp}, rd);
    endtask : rdc
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        ss_lvl = 1'b1;
        c1 = CTRL1_RESET;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdc(6'h00, CTRL1_RESET, "ctrl1 reset");
        rdc(6'h08, BAUD_RESET, "baud reset");
        apb(1'b0, 6'h18, 8'h00);
        chk("unmapped error", 1, err);
        $display("test reset done");
        for (k = 0; k < 5; k++) begin
            apb(1'b1, 6'h04, rows[k].c2);
            apb(1'b1, 6'h00, rows[k].c1);
            repeat (4) @(posedge pclk);
            chk("pin enables", rows[k].oe, {sck_oe, mosi_oe, miso_oe, ss_oe});
            if (rows[k].oe[3]) chk("sck idle", rows[k].sck, sck_out);
            rdc(6'h00, rows[k].c1, "ctrl1 readback");
        end
        $display("test pins done");
        apb(1'b1, 6'h04, 8'h10);
        apb(1'b1, 6'h24, 8'h01);
        for (k = 0; k < 4; k++) begin
            c1 = modes[k];
            apb(1'b1, 6'h00, c1);
            apb(1'b1, 6'h14, 8'h1e);
            n = 0;
            do apb(1'b0, 6'h0c, 8'h00); while (rd[SR_DONE] !== 1'b1 && ++n < 100);
            d = 8'h1e;
            if (c1[0]) d = {<<{d}};
            chk("peer rx", d, peer_rx);
            chk("clock rest", 1, pol_ok);
            chk("done irq", c1[7], irq);
            d = PEER_BYTE;
            if (c1[0]) d = {<<{d}};
            rdc(6'h14, d, "rx data");
            apb(1'b1, 6'h20, 8'h07);
            repeat (2) @(posedge pclk);
            chk("irq cleared", 0, irq);
        end
        $display("test transfers done");
        c1 = 8'h52;
        apb(1'b1, 6'h00, c1);
        apb(1'b1, 6'h14, 8'h5a);
        repeat (20) @(posedge pclk);
        chk("select in frame", 0, ss_out);
        c1 = 8'h56;
        apb(1'b1, 6'h00, c1);
        repeat (4) @(posedge pclk);
        chk("select after abort", 1, ss_out);
        repeat (200) @(posedge pclk);
        apb(1'b0, 6'h0c, 8'h00);
        chk("done after abort", 0, rd[SR_DONE]);
        $display("test abort done");
        apb(1'b1, 6'h24, 8'h00);
        c1 = 8'hd0;
        apb(1'b1, 6'h00, c1);
        ss_lvl <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(1'b0, 6'h0c, 8'h00);
        chk("fault flag", 1, rd[SR_FAULT]);
        chk("irq masked", 0, irq);
        apb(1'b1, 6'h24, 8'h04);
        repeat (2) @(posedge pclk);
        chk("fault irq", 1, irq);
        ss_lvl <= 1'b1;
        apb(1'b1, 6'h00, 8'h10);
        repeat (2) @(posedge pclk);
        chk("irq off", 0, irq);
        apb(1'b0, 6'h0c, 8'h00);
        chk("status cleared", 0, {rd[SR_DONE], rd[SR_FAULT]});
        $display("test fault done");
        end_of_test();
    end
endmodule : spi_control_and_select_config_tb_top
